// >>> design/ibsa_top.sv
`timescale 1ns/1ps
`include "ibsa_defs.svh"
module ibsa_top
	import ibsa_pkg::*;
#(
	parameter logic [4:0]   MAX_PAIRS = 5'h10,
	parameter logic [255:0] LOC_VALID = {256{1'b1}}
)(
	input  wire logic        sys_clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        test_mode_i,
	input  wire logic        tok_valid_i,
	output      logic        tok_ready_o,
	input  wire ibsa_tok_t   tok_i,
	output      logic        resp_valid_o,
	input  wire logic        resp_ready_i,
	output      ibsa_resp_t  resp_o,
	output      ibsa_bus_t   bus_o,
	input  wire logic [7:0]  bus_din_i
);
	localparam logic [7:0] PH_LAST = 8'(`IBSA_PHASE_CYC - 1);
	localparam int         TGL_MAX = 2 * `IBSA_PHASE_CYC;
	ibsa_state_t r_reg;
	ibsa_state_t r_next;
	logic [4:0]  hx;
	logic        fire;
	logic        in_test;
	logic        tmr_end;
	logic        arg_end;
	function automatic logic [4:0] hexval(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39)
			return {1'b1, 4'(c - 8'h30)};
		else if (c >= 8'h41 && c <= 8'h46)
			return {1'b1, 4'(c - 8'h37)};
		else if (c >= 8'h61 && c <= 8'h66)
			return {1'b1, 4'(c - 8'h57)};
		return 5'h00;
	endfunction
	assign hx = hexval(tok_i.ch);
	assign in_test = (r_reg.st == S_TEST);
	assign tmr_end = (r_reg.tmr == PH_LAST);
	assign tok_ready_o = (r_reg.st == S_IDLE || r_reg.st == S_ARG) && !r_reg.tm2;
	assign fire = tok_valid_i && tok_ready_o;
	assign arg_end = fire && r_reg.st == S_ARG && tok_i.kind != TK_ARG;
	assign resp_valid_o = (r_reg.st == S_RESP);
	assign resp_o = r_reg.resp;
	assign bus_o = r_reg.bus;
	always_comb
	begin
		r_next = r_reg;
		r_next.tm1 = test_mode_i;
		r_next.tm2 = r_reg.tm1;
		// Status bits from polled assemblies may still move here
		r_next.d1 = bus_din_i;
		r_next.d2 = r_reg.d1;
		unique case (r_reg.st)
			S_IDLE:
			begin
				if (r_reg.tm2)
				begin
					r_next.st = S_TEST;
					r_next.tph = 2'h0;
					r_next.tmr = 8'h00;
					r_next.tcnt = `IBSA_CNT_RST;
					r_next.tlead = 1'b0;
					r_next.tstart = 1'b0;
					r_next.bus.oe = 1'b1;
				end
				else if (fire)
				begin
					r_next.resp = '0;
					r_next.half = 1'b0;
					r_next.badp = 1'b0;
					r_next.pairs = 5'h00;
					r_next.e41 = 1'b0;
					r_next.e42 = 1'b0;
					unique case (tok_i.kind)
						TK_ADDR, TK_DATA:
						begin
							r_next.st = S_ARG;
							r_next.mdata = (tok_i.kind == TK_DATA);
						end
						TK_ADDR_Q:
						begin
							r_next.st = S_RESP;
							r_next.resp.data = r_reg.loc;
						end
						TK_DATA_Q:
						begin
							if (!LOC_VALID[r_reg.loc]
								|| !r_reg.loc[`IBSA_RD_BIT])
							begin
								r_next.st = S_RESP;
								r_next.resp.is_err = 1'b1;
								r_next.resp.code = LOC_VALID[r_reg.loc]
									? `IBSA_ERR_DIR : `IBSA_ERR_ARG;
							end
							else
							begin
								r_next.st = S_SET;
								r_next.tmr = 8'h00;
								r_next.bus.addr = r_reg.loc;
								r_next.bus.rd = 1'b1;
								r_next.bus.oe = 1'b0;
							end
						end
						default:
							r_next.st = S_IDLE;
					endcase
				end
			end
			S_ARG:
			begin
				if (fire && tok_i.kind == TK_ARG)
				begin
					if (!r_reg.half)
					begin
						r_next.half = 1'b1;
						r_next.hi = hx[3:0];
						r_next.badp = !hx[4];
					end
					else
					begin
						r_next.half = 1'b0;
						r_next.pairs = (r_reg.pairs == 5'h1f) ? r_reg.pairs
							: 5'(r_reg.pairs + 5'h01);
						if (r_reg.badp || !hx[4])
							r_next.e41 = 1'b1;
						else if (!r_reg.mdata)
							r_next.pend = {r_reg.hi, hx[3:0]};
						else if (r_reg.pairs >= MAX_PAIRS)
							r_next.e41 = 1'b1;
						else if (!LOC_VALID[r_reg.loc])
							r_next.e41 = 1'b1;
						else if (r_reg.loc[`IBSA_RD_BIT])
							r_next.e42 = 1'b1;
						else
						begin
							r_next.st = S_SET;
							r_next.tmr = 8'h00;
							r_next.bus.addr = r_reg.loc;
							r_next.bus.dout = {r_reg.hi, hx[3:0]};
							r_next.bus.oe = 1'b1;
							r_next.bus.rd = 1'b0;
						end
					end
				end
				else if (arg_end)
				begin
					// Any other token closes the argument list
					r_next.st = S_IDLE;
					if (!r_reg.mdata && !r_reg.half && !r_reg.e41
						&& r_reg.pairs == 5'h01)
						r_next.loc = r_reg.pend;
					if (r_reg.half || r_reg.e41 || r_reg.e42
						|| (!r_reg.mdata && r_reg.pairs != 5'h01))
					begin
						r_next.st = S_RESP;
						r_next.resp.is_err = 1'b1;
						r_next.resp.code = (r_reg.e42 && !r_reg.e41
							&& !r_reg.half) ? `IBSA_ERR_DIR : `IBSA_ERR_ARG;
					end
				end
			end
			S_SET, S_STB:
			begin
				r_next.tmr = 8'(r_reg.tmr + 8'h01);
				if (tmr_end)
				begin
					r_next.tmr = 8'h00;
					r_next.bus.strobe = (r_reg.st == S_SET);
					r_next.st = S_STB;
				end
				if (tmr_end && r_reg.st == S_STB)
				begin
					r_next.bus.oe = 1'b0;
					r_next.bus.rd = 1'b0;
					r_next.st = r_reg.bus.rd ? S_RESP : S_ARG;
					r_next.resp.data = r_reg.d2;
				end
			end
			S_RESP:
				if (resp_ready_i)
					r_next.st = S_IDLE;
			S_TEST:
			begin
				r_next.tmr = 8'(r_reg.tmr + 8'h01);
				if (!r_reg.tm2)
				begin
					r_next.st = S_IDLE;
					r_next.bus.strobe = 1'b0;
					r_next.bus.poll = 1'b0;
					r_next.bus.oe = 1'b0;
				end
				else if (tmr_end)
				begin
					r_next.tmr = 8'h00;
					r_next.tph = 2'(r_reg.tph + 2'h1);
					r_next.bus.strobe = r_next.tph[1];
					if (r_reg.tph == 2'h0)
					begin
						r_next.tstart = 1'b1;
						r_next.bus.poll = !r_reg.bus.poll;
						if (r_reg.tlead)
						begin
							r_next.tlead = 1'b0;
							r_next.tcnt = 8'h00;
							r_next.bus.addr = 8'h00;
						end
						else if (r_reg.tcnt == 8'hff)
						begin
							r_next.tlead = 1'b1;
							r_next.bus.addr = 8'h00;
						end
						else
						begin
							r_next.tcnt = 8'(r_reg.tcnt + 8'h01);
							r_next.bus.addr = 8'(r_reg.tcnt + 8'h01);
						end
					end
					else if (r_reg.tph == 2'h2)
						r_next.bus.dout = r_reg.tlead ? `IBSA_LEAD_DATA
							: r_reg.tcnt;
				end
			end
			default:
				r_next.st = S_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			r_reg <= '0;
			r_reg.st <= S_IDLE;
			r_reg.loc <= `IBSA_LOC_RST;
			r_reg.tcnt <= `IBSA_CNT_RST;
		end
		else
			r_reg <= r_next;
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!arst_n_i);
	sequence s_read_end;
		r_reg.st == S_STB && r_reg.bus.rd && tmr_end;
	endsequence
	sequence s_resp_data;
		r_reg.st == S_RESP && !r_reg.resp.is_err;
	endsequence
	a_test_alive: assert property ((in_test [*2]) |-> ##[1:TGL_MAX]
		($changed(r_reg.bus.strobe) || !in_test))
		else $error("strobe stuck in test mode");
	a_addr_low: assert property (($changed(r_reg.bus.addr) && in_test
		&& $past(in_test)) |-> !r_reg.bus.strobe && !$past(r_reg.bus.strobe))
		else $error("address moved with strobe high");
	a_data_high: assert property (($changed(r_reg.bus.dout) && in_test
		&& $past(in_test)) |-> r_reg.bus.strobe && $past(r_reg.bus.strobe))
		else $error("data moved with strobe low");
	a_count_step: assert property (($changed(r_reg.bus.addr) && in_test
		&& $past(r_reg.tstart)) |-> r_reg.bus.addr ==
		8'($past(r_reg.bus.addr) + 8'h01))
		else $error("address pattern not a binary count");
	a_lead_pulse: assert property (($changed(r_reg.bus.dout) && in_test
		&& r_reg.tlead) |-> r_reg.bus.dout == `IBSA_LEAD_DATA)
		else $error("lead pulse wrong");
	a_byte_form: assert property ((r_reg.st == S_SET
		&& $past(r_reg.st) == S_ARG) |-> r_reg.bus.dout ==
		{$past(r_reg.hi), $past(hx[3:0])})
		else $error("byte digits misplaced");
	a_loc_kept: assert property ($changed(r_reg.loc) |->
		$past(arg_end && !r_reg.mdata && !r_reg.half && !r_reg.e41))
		else $error("location changed without valid command");
	a_addr_err: assert property ((arg_end && !r_reg.mdata && r_reg.half)
		|=> r_reg.st == S_RESP && r_reg.resp.code == `IBSA_ERR_ARG)
		else $error("unpaired location digit not reported");
	a_write_loc: assert property (($rose(r_reg.bus.strobe) && !in_test
		&& !r_reg.bus.rd) |-> r_reg.bus.addr == r_reg.loc && r_reg.bus.oe
		&& !r_reg.loc[`IBSA_RD_BIT] && LOC_VALID[r_reg.loc])
		else $error("write to wrong location");
	a_bad_skip: assert property ((fire && r_reg.st == S_ARG && r_reg.mdata
		&& tok_i.kind == TK_ARG && r_reg.half && !hx[4]) |=>
		r_reg.st == S_ARG && r_reg.e41)
		else $error("bad pair not skipped");
	a_query_ret: assert property (s_read_end |=> s_resp_data
		and (r_reg.resp.data == $past(r_reg.d2)))
		else $error("query data not returned");
	a_addr_query: assert property ((fire && r_reg.st == S_IDLE
		&& tok_i.kind == TK_ADDR_Q) |=> s_resp_data
		and (r_reg.resp.data == $past(r_reg.loc)))
		else $error("location query wrong");
	a_dir_err: assert property ((fire && r_reg.st == S_IDLE
		&& tok_i.kind == TK_DATA_Q && LOC_VALID[r_reg.loc]
		&& !r_reg.loc[`IBSA_RD_BIT]) |=> r_reg.st == S_RESP
		&& r_reg.resp.code == `IBSA_ERR_DIR)
		else $error("direction error not reported");
endmodule // ibsa_top

// >>> design/ibsa_defs.svh
// What this block does
// - Test mode drives repeating bus pattern continuously
// - Address changes strobe low, data strobe high
// - Binary count pattern, 80 cycles on LSB
// - Extra lead pulse on upper data nibble
// - Location command: two hex digits, MSD first
// - Bad location argument unused, error reported
// - Location query returns current location
// - Data command: up to 16 bytes sent
// - Bad data pair skipped, error reported
// - Invalid location for data reports error
// - Data query reads bus at location
// - Token closing a list is consumed, not run as a command
// - Code 41 bad argument, 42 direction mismatch
// - First digit bits 7-4, second 3-0
`ifndef IBSA_DEFS_SVH
`define IBSA_DEFS_SVH
`define IBSA_CLK_MHZ    200
`define IBSA_PHASE_NS   100
`define IBSA_PHASE_CYC  ((`IBSA_PHASE_NS * `IBSA_CLK_MHZ + 999) / 1000)
`define IBSA_ERR_ARG    8'h29
`define IBSA_ERR_DIR    8'h2a
`define IBSA_RD_BIT     7
`define IBSA_LEAD_DATA  8'hf0
`define IBSA_LOC_RST    8'h00
`define IBSA_CNT_RST    8'hff
`endif

// >>> design/ibsa_pkg.sv
package ibsa_pkg;
	typedef enum logic [2:0] {
		TK_ADDR,
		TK_ADDR_Q,
		TK_DATA,
		TK_DATA_Q,
		TK_ARG,
		TK_END
	} ibsa_kind_t;
	typedef struct packed {
		ibsa_kind_t  kind;
		logic [7:0]  ch;
	} ibsa_tok_t;
	typedef struct packed {
		logic        is_err;
		logic [7:0]  code;
		logic [7:0]  data;
	} ibsa_resp_t;
	typedef struct packed {
		logic [7:0]  addr;
		logic [7:0]  dout;
		logic        oe;
		logic        strobe;
		logic        poll;
		logic        rd;
	} ibsa_bus_t;
	typedef enum logic [2:0] {
		S_IDLE,
		S_ARG,
		S_SET,
		S_STB,
		S_RESP,
		S_TEST
	} ibsa_st_t;
	typedef struct packed {
		ibsa_st_t    st;
		logic        tm1;
		logic        tm2;
		logic [7:0]  d1;
		logic [7:0]  d2;
		logic [7:0]  tmr;
		logic [1:0]  tph;
		logic [7:0]  tcnt;
		logic        tlead;
		logic        tstart;
		logic [7:0]  loc;
		logic [7:0]  pend;
		logic [3:0]  hi;
		logic        half;
		logic        badp;
		logic        mdata;
		logic [4:0]  pairs;
		logic        e41;
		logic        e42;
		ibsa_bus_t   bus;
		ibsa_resp_t  resp;
	} ibsa_state_t;
endpackage

// >>> tb/ibsa_bus_model.sv
`timescale 1ns/1ps
module ibsa_bus_model
	import ibsa_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire ibsa_bus_t  bus_i,
	output      logic [7:0] bus_din_o
);
	// Idle lines keep moving so a stale value never reads as data
	initial
	begin
		bus_din_o = 8'h00;
		forever
		begin
			@(posedge sys_clk_i);
			if (bus_i.rd)
				bus_din_o <= bus_i.addr ^ 8'h5a;
			else if (bus_i.poll && !bus_i.strobe)
				bus_din_o <= {~bus_din_o[7:5], 5'h15};
			else
				bus_din_o <= ~bus_din_o;
		end
	end
endmodule // ibsa_bus_model

// >>> tb/ibsa_top_tb.sv
`timescale 1ns/1ps
`include "ibsa_defs.svh"
module ibsa_top_tb
	import ibsa_pkg::*;
;
	typedef struct { string s; logic [7:0] v; } ibsa_row_t;
	logic        sys_clk_i = 0, arst_n_i = 0, test_mode_i = 0;
	logic        tok_valid_i = 0, resp_ready_i = 1;
	ibsa_tok_t   tok_i = '0;
	logic        tok_ready_o, resp_valid_o;
	ibsa_resp_t  resp_o;
	ibsa_bus_t   bus_o;
	logic [7:0]  din, pa, pd;
	logic        ps;
	int          err_count = 0, n_checks = 0, n;
	ibsa_resp_t  rq[$];
	logic [15:0] wq[$];
	logic [16:0] tq[$];
	string       hx = "0123456789ABCDEF", s;
	ibsa_row_t   rows[4] = '{'{"4B", 8'h4b}, '{"0F", 8'h0f},
		'{"F3", 8'hf3}, '{"80", 8'h80}};

	// Location 55 left out of the valid map on purpose
	ibsa_top #(.LOC_VALID(~(256'h1 << 8'h55))) u_ibsa_top (
		.sys_clk_i    (sys_clk_i),
		.arst_n_i     (arst_n_i),
		.test_mode_i  (test_mode_i),
		.tok_valid_i  (tok_valid_i),
		.tok_ready_o  (tok_ready_o),
		.tok_i        (tok_i),
		.resp_valid_o (resp_valid_o),
		.resp_ready_i (resp_ready_i),
		.resp_o       (resp_o),
		.bus_o        (bus_o),
		.bus_din_i    (din)
	);
	ibsa_bus_model u_ibsa_bus_model (
		.sys_clk_i (sys_clk_i),
		.bus_i     (bus_o),
		.bus_din_o (din)
	);

	initial forever #2.5 sys_clk_i = ~sys_clk_i;

	task automatic check(input logic [16:0] seen, exp, input string m);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask

	task automatic report_and_stop;
		if (err_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Bubble cycle between tokens keeps valid to one write per step
	task automatic send(input ibsa_kind_t k, input logic [7:0] c);
		int w;
		w = 0;
		@(posedge sys_clk_i);
		#1;
		tok_i.kind = k;
		tok_i.ch = c;
		tok_valid_i = 1;
		while (tok_ready_o !== 1'b1 && w < 2000)
		begin
			@(posedge sys_clk_i);
			#1;
			w++;
		end
		check(17'(w < 2000), 17'd1, "token refused");
		@(posedge sys_clk_i);
		#1;
		tok_valid_i = 0;
	endtask

	task automatic cmd(input ibsa_kind_t k, input string a);
		send(k, 8'h00);
		foreach (a[i])
			send(TK_ARG, a[i]);
		send(TK_END, 8'h00);
	endtask

	task automatic expect_resp(input logic e, input logic [7:0] v);
		ibsa_resp_t r;
		int w;
		w = 0;
		r = 'x;
		while (rq.size() == 0 && w < 100)
		begin
			@(posedge sys_clk_i);
			#1;
			w++;
		end
		if (rq.size() > 0)
			r = rq.pop_front();
		check({r.is_err, e ? r.code : r.data}, {e, v}, "response");
	endtask

	always @(posedge sys_clk_i)
	begin
		if (resp_valid_o === 1'b1 && resp_ready_i)
			rq.push_back(resp_o);
		if (bus_o.strobe && !ps && bus_o.oe && !bus_o.rd && !test_mode_i)
			wq.push_back({bus_o.addr, bus_o.dout});
		if (test_mode_i && ps && !bus_o.strobe)
			tq.push_back({bus_o.poll, bus_o.addr, bus_o.dout});
		if (test_mode_i && tq.size() > 0 && bus_o.addr != pa)
			check({ps, bus_o.strobe}, 2'b00, "addr moved");
		if (test_mode_i && tq.size() > 0 && bus_o.dout != pd)
			check({ps, bus_o.strobe}, 2'b11, "data moved");
		{pa, pd, ps} <= {bus_o.addr, bus_o.dout, bus_o.strobe};
	end

	initial
	begin
		#400000;
		err_count++;
		report_and_stop();
	end

	initial
	begin
		repeat (4) @(posedge sys_clk_i);
		#1;
		check({tok_ready_o, resp_valid_o, bus_o.oe, bus_o.strobe}, 4'h8,
			"reset");
		arst_n_i = 1;
		send(TK_ADDR_Q, 8'h00);
		expect_resp(0, 8'h00);
		foreach (rows[i])
		begin
			cmd(TK_ADDR, rows[i].s);
			send(TK_ADDR_Q, 8'h00);
			expect_resp(0, rows[i].v);
		end
		cmd(TK_ADDR, "4G");
		expect_resp(1, `IBSA_ERR_ARG);
		cmd(TK_ADDR, "4");
		expect_resp(1, `IBSA_ERR_ARG);
		resp_ready_i = 0;
		send(TK_ADDR_Q, 8'h00);
		repeat (30) @(posedge sys_clk_i);
		#1;
		check({resp_valid_o, tok_ready_o, resp_o.data}, 10'h280,
			"held");
		resp_ready_i = 1;
		expect_resp(0, 8'h80);
		cmd(TK_ADDR, "3F");
		cmd(TK_DATA, "121ZAB");
		expect_resp(1, `IBSA_ERR_ARG);
		check(17'(wq.size()), 17'd2, "wr count");
		check(wq[0], 16'h3f12, "wr first");
		check(wq[1], 16'h3fab, "wr after bad");
		wq.delete();
		s = "";
		for (int i = 0; i < 17; i++)
			s = {s, hx.substr(i / 16, i / 16), hx.substr(i % 16, i % 16)};
		cmd(TK_DATA, s);
		expect_resp(1, `IBSA_ERR_ARG);
		check(17'(wq.size()), 17'd16, "count");
		foreach (wq[i])
			check(wq[i], {8'h3f, 8'(i)}, "write");
		wq.delete();
		send(TK_DATA_Q, 8'h00);
		expect_resp(1, `IBSA_ERR_DIR);
		cmd(TK_ADDR, "F3");
		send(TK_DATA_Q, 8'h00);
		check({bus_o.rd, bus_o.oe, bus_o.addr}, 10'h2f3, "read");
		expect_resp(0, 8'hf3 ^ 8'h5a);
		cmd(TK_DATA, "11");
		expect_resp(1, `IBSA_ERR_DIR);
		cmd(TK_ADDR, "55");
		cmd(TK_DATA, "11");
		expect_resp(1, `IBSA_ERR_ARG);
		send(TK_DATA_Q, 8'h00);
		expect_resp(1, `IBSA_ERR_ARG);
		check(17'(wq.size()), 17'd0, "stray write");
		test_mode_i = 1;
		n = 0;
		while (tq.size() < 258 && n < 30000)
		begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
		check(17'(tq.size() >= 258), 17'd1, "steps");
		foreach (tq[i])
			if (i < 258)
			begin
				check(tq[i][15:0], (i % 257 == 0) ? 16'h00f0 :
					{2{8'(i - 1)}}, "pattern");
				if (i > 0)
					check(tq[i][16], !tq[i - 1][16], "poll");
			end
		check(bus_o.oe, 1'b1, "drive");
		test_mode_i = 0;
		repeat (10) @(posedge sys_clk_i);
		#1;
		check({tok_ready_o, bus_o.oe, bus_o.strobe, bus_o.poll}, 4'h8,
			"exit");
		report_and_stop();
	end
endmodule // ibsa_top_tb
